// ---- design/amafc_cmd.sv ----
// Command interpreter for max-address, read-native-max and set-features commands.
// Assumes a same-clock task-file front end: host values stand while cmd_valid is high.
`timescale 1ns/100ps
module amafc_cmd #(
	parameter logic [47:0] NATIVE_MAX = amafc_pkg::NATIVE_MAX_DEFAULT
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic power_on,
	input wire logic soft_reset,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic [7:0] features_reg,
	input wire logic [7:0] sector_count_reg,
	input wire logic [7:0] sector_number_reg,
	input wire logic [15:0] cylinder_reg,
	input wire logic [3:0] head_reg,
	input wire logic [7:0] drive_select_reg,
	input wire logic [7:0] lba_low_prev,
	input wire logic [7:0] lba_mid_prev,
	input wire logic [7:0] lba_high_prev,
	input wire logic acc_valid,
	input wire logic [47:0] acc_lba,
	output logic cmd_ready,
	output logic cmd_done,
	output logic cmd_abort,
	output logic cmd_idnf,
	output logic [7:0] sector_number_ret,
	output logic [15:0] cylinder_ret,
	output logic [3:0] head_ret,
	output logic [7:0] lba_low_prev_ret,
	output logic [7:0] lba_mid_prev_ret,
	output logic [7:0] lba_high_prev_ret,
	output logic acc_done,
	output logic acc_abort,
	output logic frozen,
	output logic [47:0] max_lba,
	output logic [31:0] id_words_60_61,
	output logic [63:0] id_words_100_103,
	output logic write_cache_en,
	output logic look_ahead_en,
	output logic apm_en,
	output logic [1:0] apm_mode,
	output logic soft_revert_en,
	output logic [2:0] pio_mode,
	output logic iordy_off,
	output logic udma_sel,
	output logic [2:0] dma_mode,
	output logic [7:0] multiple_count,
	output logic [7:0] ecc_bytes
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} amafc_state_e;

	typedef struct packed {
		amafc_state_e state;
		logic rdy;
		logic [7:0] op;
		logic [7:0] ft;
		logic [7:0] sc;
		logic [7:0] sn;
		logic [15:0] cyl;
		logic [3:0] hd;
		logic lba_mode;
		logic [23:0] prev;
		logic [7:0] last_op;
		logic pw_set;
		logic frozen;
		logic hpa28;
		logic vol_once;
		logic done;
		logic abort;
		logic idnf;
		logic [7:0] ret_sn;
		logic [15:0] ret_cyl;
		logic [3:0] ret_hd;
		logic [23:0] ret_prev;
		logic acc_done;
		logic acc_abort;
		logic wc;
		logic rla;
		logic apm_en;
		logic [1:0] apm_mode;
		logic revert;
		logic [2:0] pio;
		logic iordy_off;
		logic udma;
		logic [2:0] dma;
		logic [7:0] multi;
		logic [7:0] ecc;
		logic set_stb;
		logic [47:0] set_lba;
		logic set_keep;
	} amafc_state_s;

	amafc_state_s q_reg;
	amafc_state_s q_next;
	logic [47:0] cur_max;
	logic [47:0] nat28;

	// Power-on and hard-reset feature defaults, also used by a reverting soft reset
	function automatic amafc_state_s with_defaults(input amafc_state_s s);
		amafc_state_s r;
		r = s;
		r.wc = 1'b1;
		r.rla = 1'b1;
		r.apm_en = 1'b1;
		r.apm_mode = amafc_pkg::APM_MODE1;
		r.revert = 1'b0;
		r.pio = amafc_pkg::DEF_PIO_MODE;
		r.iordy_off = 1'b0;
		r.udma = 1'b0;
		r.dma = amafc_pkg::DEF_DMA_MODE;
		r.multi = amafc_pkg::DEF_MULTIPLE;
		r.ecc = amafc_pkg::DEF_ECC_BYTES;
		return r;
	endfunction : with_defaults

	function automatic amafc_state_s reset_value();
		amafc_state_s r;
		r = '0;
		r.state = ST_IDLE;
		r.rdy = 1'b1;
		return with_defaults(r);
	endfunction : reset_value

	assign nat28 = (NATIVE_MAX > amafc_pkg::LBA28_LIMIT) ?
		{20'h00000, amafc_pkg::LBA28_CLAMP} : NATIVE_MAX;

	always_comb begin
		q_next = q_reg;
		q_next.done = 1'b0;
		q_next.abort = 1'b0;
		q_next.idnf = 1'b0;
		q_next.set_stb = 1'b0;
		q_next.acc_done = acc_valid;
		q_next.acc_abort = acc_valid && (acc_lba > cur_max);
		if (soft_reset && q_reg.revert) begin
			q_next = with_defaults(q_next);
		end
		case (q_reg.state)
			ST_IDLE: begin
				if (cmd_valid) begin
					q_next.state = ST_EXEC;
					q_next.rdy = 1'b0;
					q_next.op = cmd_opcode;
					q_next.ft = features_reg;
					q_next.sc = sector_count_reg;
					q_next.sn = sector_number_reg;
					q_next.cyl = cylinder_reg;
					q_next.hd = head_reg;
					q_next.lba_mode = drive_select_reg[amafc_pkg::LBA_BIT];
					q_next.prev = {lba_high_prev, lba_mid_prev, lba_low_prev};
				end
			end
			ST_EXEC: begin
				q_next.state = ST_IDLE;
				q_next.rdy = 1'b1;
				q_next.last_op = q_reg.op;
				q_next.done = 1'b1;
				case (q_reg.op)
					amafc_pkg::OP_SET_MAX: begin
						if (q_reg.frozen) begin
							// Stored maximum stays untouched on this path
							if (q_reg.ft != amafc_pkg::SUB_FREEZE
								|| q_reg.last_op == amafc_pkg::OP_READ_NATIVE) begin
								q_next.abort = 1'b1;
							end
						end else if (q_reg.last_op == amafc_pkg::OP_READ_NATIVE) begin
							if (q_reg.sc[amafc_pkg::VOLATILE_BIT] && q_reg.vol_once) begin
								q_next.idnf = 1'b1;
							end else if (q_reg.lba_mode) begin
								// Plain set-max whatever the features value
								q_next.set_stb = 1'b1;
								q_next.set_lba = {20'h00000, q_reg.hd, q_reg.cyl, q_reg.sn};
								q_next.set_keep = q_reg.sc[amafc_pkg::VOLATILE_BIT];
								q_next.hpa28 = 1'b1;
								q_next.vol_once = q_reg.vol_once
									| q_reg.sc[amafc_pkg::VOLATILE_BIT];
							end
						end else begin
							case (q_reg.ft)
								amafc_pkg::SUB_SET_PASSWORD: q_next.pw_set = 1'b1;
								amafc_pkg::SUB_LOCK: q_next.abort = 1'b0;
								amafc_pkg::SUB_UNLOCK: q_next.abort = 1'b0;
								amafc_pkg::SUB_FREEZE: begin
									if (q_reg.pw_set) begin
										q_next.frozen = 1'b1;
									end else begin
										q_next.abort = 1'b1;
									end
								end
								default: q_next.abort = 1'b1;
							endcase
						end
					end
					amafc_pkg::OP_SET_MAX_EXT: begin
						if (q_reg.last_op != amafc_pkg::OP_READ_NATIVE_EXT) begin
							q_next.abort = 1'b1;
						end else if (q_reg.hpa28) begin
							q_next.abort = 1'b1;
						end else if (q_reg.sc[amafc_pkg::VOLATILE_BIT] && q_reg.vol_once) begin
							q_next.idnf = 1'b1;
						end else begin
							q_next.set_stb = 1'b1;
							q_next.set_lba = {q_reg.prev, q_reg.cyl[15:8], q_reg.cyl[7:0],
								q_reg.sn};
							q_next.set_keep = q_reg.sc[amafc_pkg::VOLATILE_BIT];
							q_next.vol_once = q_reg.vol_once
								| q_reg.sc[amafc_pkg::VOLATILE_BIT];
						end
					end
					amafc_pkg::OP_READ_NATIVE: begin
						if (q_reg.lba_mode) begin
							q_next.ret_sn = nat28[7:0];
							q_next.ret_cyl = nat28[23:8];
							q_next.ret_hd = nat28[27:24];
						end else begin
							q_next.ret_sn = amafc_pkg::CHS_MAX_SECTOR;
							q_next.ret_cyl = amafc_pkg::CHS_MAX_CYL;
							q_next.ret_hd = amafc_pkg::CHS_MAX_HEAD;
						end
					end
					amafc_pkg::OP_READ_NATIVE_EXT: begin
						q_next.ret_sn = NATIVE_MAX[7:0];
						q_next.ret_cyl = NATIVE_MAX[23:8];
						q_next.ret_prev = NATIVE_MAX[47:24];
					end
					amafc_pkg::OP_SET_FEATURES: begin
						// Task-file copies are not written on any features path
						case (q_reg.ft)
							amafc_pkg::FT_WCACHE_ON: q_next.wc = 1'b1;
							amafc_pkg::FT_WCACHE_OFF: q_next.wc = 1'b0;
							amafc_pkg::FT_LOOKAHEAD_ON: q_next.rla = 1'b1;
							amafc_pkg::FT_LOOKAHEAD_OFF: q_next.rla = 1'b0;
							amafc_pkg::FT_REVERT_OFF: q_next.revert = 1'b0;
							amafc_pkg::FT_REVERT_ON: q_next.revert = 1'b1;
							amafc_pkg::FT_APM_OFF: begin
								q_next.apm_en = 1'b0;
								q_next.apm_mode = amafc_pkg::APM_MODE1;
							end
							amafc_pkg::FT_APM_ON: begin
								if (q_reg.sc == amafc_pkg::APM_INVALID_LO
									|| q_reg.sc == amafc_pkg::APM_INVALID_HI) begin
									q_next.abort = 1'b1;
								end else begin
									q_next.apm_en = 1'b1;
									if (q_reg.sc >= amafc_pkg::APM_M0_LO) begin
										q_next.apm_mode = amafc_pkg::APM_MODE0;
									end else if (q_reg.sc >= amafc_pkg::APM_M1_LO) begin
										q_next.apm_mode = amafc_pkg::APM_MODE1;
									end else begin
										q_next.apm_mode = amafc_pkg::APM_MODE2;
									end
								end
							end
							amafc_pkg::FT_XFER_MODE: begin
								case (q_reg.sc[7:3])
									amafc_pkg::XT_PIO_DEFAULT: begin
										if (q_reg.sc[2:0] == amafc_pkg::XT_DEFAULT_IORDY_ON
											|| q_reg.sc[2:0] == amafc_pkg::XT_DEFAULT_IORDY_OFF) begin
											q_next.pio = amafc_pkg::DEF_PIO_MODE;
											q_next.iordy_off = q_reg.sc[0];
										end else begin
											q_next.abort = 1'b1;
										end
									end
									amafc_pkg::XT_PIO_FLOW: begin
										q_next.pio = q_reg.sc[2:0];
										q_next.iordy_off = 1'b0;
									end
									amafc_pkg::XT_MWDMA: begin
										q_next.udma = 1'b0;
										q_next.dma = q_reg.sc[2:0];
									end
									amafc_pkg::XT_UDMA: begin
										q_next.udma = 1'b1;
										q_next.dma = q_reg.sc[2:0];
									end
									default: q_next.abort = 1'b1;
								endcase
							end
							default: q_next.abort = 1'b1;
						endcase
					end
					default: begin
						// Commands owned elsewhere only update the sequencing history
						q_next.done = 1'b0;
					end
				endcase
			end
			default: q_next = reset_value();
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			q_reg <= reset_value();
		end else begin
			q_reg <= q_next;
		end
	end

	amafc_max_store #(
		.NATIVE_MAX(NATIVE_MAX)
	) u_store (
		.clk(clk),
		.reset(reset),
		.power_on(power_on),
		.set_stb(q_reg.set_stb),
		.set_lba(q_reg.set_lba),
		.set_keep(q_reg.set_keep),
		.max_lba(cur_max),
		.id_words_60_61(id_words_60_61),
		.id_words_100_103(id_words_100_103)
	);

	assign cmd_ready = q_reg.rdy;
	assign cmd_done = q_reg.done;
	assign cmd_abort = q_reg.abort;
	assign cmd_idnf = q_reg.idnf;
	assign sector_number_ret = q_reg.ret_sn;
	assign cylinder_ret = q_reg.ret_cyl;
	assign head_ret = q_reg.ret_hd;
	assign lba_low_prev_ret = q_reg.ret_prev[7:0];
	assign lba_mid_prev_ret = q_reg.ret_prev[15:8];
	assign lba_high_prev_ret = q_reg.ret_prev[23:16];
	assign acc_done = q_reg.acc_done;
	assign acc_abort = q_reg.acc_abort;
	assign frozen = q_reg.frozen;
	assign max_lba = cur_max;
	assign write_cache_en = q_reg.wc;
	assign look_ahead_en = q_reg.rla;
	assign apm_en = q_reg.apm_en;
	assign apm_mode = q_reg.apm_mode;
	assign soft_revert_en = q_reg.revert;
	assign pio_mode = q_reg.pio;
	assign iordy_off = q_reg.iordy_off;
	assign udma_sel = q_reg.udma;
	assign dma_mode = q_reg.dma;
	assign multiple_count = q_reg.multi;
	assign ecc_bytes = q_reg.ecc;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_exec(logic [7:0] opc);
		q_reg.state == ST_EXEC && q_reg.op == opc;
	endsequence

	property p_freeze_needs_pwd;
		$rose(q_reg.frozen) |-> $past(q_reg.pw_set);
	endproperty
	a_freeze_needs_pwd: assert property (p_freeze_needs_pwd) else $error("frozen without password");

	property p_frozen_rejects;
		s_exec(amafc_pkg::OP_SET_MAX) ##0 (q_reg.frozen && q_reg.ft != amafc_pkg::SUB_FREEZE)
			|=> cmd_abort && cmd_done ##1 $stable(cur_max);
	endproperty
	a_frozen_rejects: assert property (p_frozen_rejects) else $error("frozen accepted set max");

	property p_ext_needs_native;
		s_exec(amafc_pkg::OP_SET_MAX_EXT) ##0 q_reg.last_op != amafc_pkg::OP_READ_NATIVE_EXT
			|=> cmd_abort ##1 $stable(cur_max);
	endproperty
	a_ext_needs_native: assert property (p_ext_needs_native) else $error("ext set not aborted");

	property p_hpa28_blocks_ext;
		s_exec(amafc_pkg::OP_SET_MAX_EXT) ##0 q_reg.hpa28 |=> cmd_abort;
	endproperty
	a_hpa28_blocks_ext: assert property (p_hpa28_blocks_ext) else $error("ext set over 28-bit area");

	property p_access_abort;
		acc_valid && (acc_lba > cur_max) |=> acc_done && acc_abort;
	endproperty
	a_access_abort: assert property (p_access_abort) else $error("access beyond max not aborted");

	property p_bad_feature;
		s_exec(amafc_pkg::OP_SET_FEATURES) ##0 (q_reg.ft == 8'h00 || q_reg.ft == 8'hFF)
			|=> cmd_abort && $stable(write_cache_en) && $stable(apm_mode);
	endproperty
	a_bad_feature: assert property (p_bad_feature) else $error("invalid feature accepted");

	property p_clamp28;
		s_exec(amafc_pkg::OP_READ_NATIVE) ##0 q_reg.lba_mode
			|=> {head_ret, cylinder_ret, sector_number_ret}
				== ((NATIVE_MAX > amafc_pkg::LBA28_LIMIT) ? amafc_pkg::LBA28_CLAMP : NATIVE_MAX[27:0]);
	endproperty
	a_clamp28: assert property (p_clamp28) else $error("28-bit native max wrong");

	property p_apm_off_mode1;
		s_exec(amafc_pkg::OP_SET_FEATURES) ##0 q_reg.ft == amafc_pkg::FT_APM_OFF
			|=> !apm_en && apm_mode == amafc_pkg::APM_MODE1;
	endproperty
	a_apm_off_mode1: assert property (p_apm_off_mode1) else $error("power mode not one");

	property p_second_volatile;
		s_exec(amafc_pkg::OP_SET_MAX_EXT) ##0 (q_reg.vol_once && q_reg.sc[0] && !q_reg.hpa28
			&& q_reg.last_op == amafc_pkg::OP_READ_NATIVE_EXT) |=> cmd_idnf && !cmd_abort;
	endproperty
	a_second_volatile: assert property (p_second_volatile) else $error("second keep set allowed");
endmodule : amafc_cmd

// ---- design/amafc_pkg.sv ----
// Constants for the max-address and set-features command interpreter.
// Assumes a task-file front end on the same clock that pulses one command at a time.
// Behaviour
// - Freeze lock needs an earlier password set
// - Subcommand after F8h acts as set-max in LBA mode
// - Frozen state rejects every F9h subcommand except a freeze lock not following F8h
// - Ext max LBA built from current and previous
// - Access beyond the maximum reports abort
// - New maximum shows in identify words
// - Ext set-max must follow ext read-native
// - Second volatile-one set reports ID-not-found
// - Prior 28-bit protected area aborts ext set
// - Volatile bit zero reverts at hard reset
// - Read native loads maximum into task file
// - 28-bit read native clamps large maxima
// - Ext read native returns full 48 bits
// - Write cache and look-ahead enable codes
// - Power management and revert-default codes
// - Unknown features value aborts the command
// - Transfer mode chosen from sector count
// - Default PIO codes, with IORDY option
// - Power management level from sector count
// - Power management off runs mode one
// - Hard reset restores the feature defaults
package amafc_pkg;
	localparam logic [7:0] OP_SET_MAX = 8'hF9;
	localparam logic [7:0] OP_READ_NATIVE = 8'hF8;
	localparam logic [7:0] OP_SET_MAX_EXT = 8'h37;
	localparam logic [7:0] OP_READ_NATIVE_EXT = 8'h27;
	localparam logic [7:0] OP_SET_FEATURES = 8'hEF;
	localparam logic [7:0] SUB_SET_PASSWORD = 8'h01;
	localparam logic [7:0] SUB_LOCK = 8'h02;
	localparam logic [7:0] SUB_UNLOCK = 8'h03;
	localparam logic [7:0] SUB_FREEZE = 8'h04;
	localparam logic [7:0] FT_WCACHE_ON = 8'h02;
	localparam logic [7:0] FT_XFER_MODE = 8'h03;
	localparam logic [7:0] FT_APM_ON = 8'h05;
	localparam logic [7:0] FT_LOOKAHEAD_OFF = 8'h55;
	localparam logic [7:0] FT_REVERT_OFF = 8'h66;
	localparam logic [7:0] FT_WCACHE_OFF = 8'h82;
	localparam logic [7:0] FT_APM_OFF = 8'h85;
	localparam logic [7:0] FT_LOOKAHEAD_ON = 8'hAA;
	localparam logic [7:0] FT_REVERT_ON = 8'hCC;
	localparam logic [4:0] XT_PIO_DEFAULT = 5'h00;
	localparam logic [4:0] XT_PIO_FLOW = 5'h01;
	localparam logic [4:0] XT_MWDMA = 5'h04;
	localparam logic [4:0] XT_UDMA = 5'h08;
	localparam logic [2:0] XT_DEFAULT_IORDY_ON = 3'h0;
	localparam logic [2:0] XT_DEFAULT_IORDY_OFF = 3'h1;
	localparam logic [2:0] DEF_PIO_MODE = 3'h4;
	localparam logic [2:0] DEF_DMA_MODE = 3'h2;
	localparam logic [7:0] APM_M0_LO = 8'hC0;
	localparam logic [7:0] APM_M1_LO = 8'h80;
	localparam logic [7:0] APM_M2_LO = 8'h01;
	localparam logic [7:0] APM_INVALID_HI = 8'hFF;
	localparam logic [7:0] APM_INVALID_LO = 8'h00;
	localparam logic [1:0] APM_MODE0 = 2'h0;
	localparam logic [1:0] APM_MODE1 = 2'h1;
	localparam logic [1:0] APM_MODE2 = 2'h2;
	localparam logic [7:0] DEF_MULTIPLE = 8'h10;
	localparam logic [7:0] DEF_ECC_BYTES = 8'h04;
	localparam int VOLATILE_BIT = 0;
	localparam int LBA_BIT = 6;
	localparam logic [47:0] LBA28_LIMIT = 48'h0000_0FFF_FFFF;
	localparam logic [27:0] LBA28_CLAMP = 28'hFFF_FFFE;
	localparam logic [15:0] CHS_MAX_CYL = 16'h3FFF;
	localparam logic [3:0] CHS_MAX_HEAD = 4'hF;
	localparam logic [7:0] CHS_MAX_SECTOR = 8'h3F;
	localparam logic [47:0] NATIVE_MAX_DEFAULT = 48'h0000_2000_0000;
endpackage : amafc_pkg

// ---- design/amafc_max_store.sv ----
// Holds the current and the persistent maximum LBA and the identify words built from it.
// Assumes power_on is high together with reset only at a power-on reset.
`timescale 1ns/100ps
module amafc_max_store #(
	parameter logic [47:0] NATIVE_MAX = amafc_pkg::NATIVE_MAX_DEFAULT
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic power_on,
	input wire logic set_stb,
	input wire logic [47:0] set_lba,
	input wire logic set_keep,
	output logic [47:0] max_lba,
	output logic [31:0] id_words_60_61,
	output logic [63:0] id_words_100_103
);
	typedef struct packed {
		logic [47:0] cur;
		logic [47:0] keep;
		logic [31:0] w60;
		logic [63:0] w100;
	} amafc_store_s;

	amafc_store_s q_reg;
	amafc_store_s q_next;
	logic [47:0] cap;

	always_comb begin
		q_next = q_reg;
		if (set_stb) begin
			q_next.cur = set_lba;
			if (set_keep) begin
				q_next.keep = set_lba;
			end
		end
		cap = q_next.cur + 48'h0000_0000_0001;
		// Word 60-61 saturates at the 28-bit limit; 100-103 carry the full count
		q_next.w60 = (q_next.cur >= amafc_pkg::LBA28_LIMIT) ? 32'h0FFF_FFFF : cap[31:0];
		q_next.w100 = {16'h0000, cap};
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			// Hard reset falls back to the last persistent value, power-on to native
			q_reg.keep <= power_on ? NATIVE_MAX : q_reg.keep;
			q_reg.cur <= power_on ? NATIVE_MAX : q_reg.keep;
			q_reg.w60 <= 32'h0000_0000;
			q_reg.w100 <= 64'h0000_0000_0000_0000;
		end else begin
			q_reg <= q_next;
		end
	end

	assign max_lba = q_reg.cur;
	assign id_words_60_61 = q_reg.w60;
	assign id_words_100_103 = q_reg.w100;
endmodule : amafc_max_store

// ---- tb/amafc_host.sv ----
// Host adapter model: places one task-file command at a time and collects its status.
// Assumes the interpreter's ready/done handshake on the shared clock.
`timescale 1ns/100ps
module amafc_host (
	input wire logic clk,
	input wire logic cmd_ready,
	input wire logic cmd_done,
	input wire logic cmd_abort,
	input wire logic cmd_idnf,
	output logic cmd_valid,
	output logic [7:0] cmd_opcode,
	output logic [7:0] features_reg,
	output logic [7:0] sector_count_reg,
	output logic [7:0] sector_number_reg,
	output logic [15:0] cylinder_reg,
	output logic [3:0] head_reg,
	output logic [7:0] drive_select_reg,
	output logic [7:0] lba_low_prev,
	output logic [7:0] lba_mid_prev,
	output logic [7:0] lba_high_prev
);
	initial begin
		cmd_valid = 1'b0;
		{cmd_opcode, features_reg, sector_count_reg, drive_select_reg, head_reg} = 36'h0;
		{lba_high_prev, lba_mid_prev, lba_low_prev, cylinder_reg, sector_number_reg} = 48'h0;
	end

	// Status comes back as {idnf, abort}; x when no completion was seen
	task automatic issue(input logic [7:0] op, ft, sc, drv, input logic [47:0] lba,
		output logic [1:0] st);
		int n;
		cmd_valid = 1'b1;
		{cmd_opcode, features_reg, sector_count_reg, drive_select_reg} = {op, ft, sc, drv};
		{lba_high_prev, lba_mid_prev, lba_low_prev, cylinder_reg, sector_number_reg} = lba;
		head_reg = lba[27:24];
		// Ready is looked at between edges; the take is the next edge after it stands
		while (cmd_ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		// Released lines show the inverse so a late sample cannot match by luck
		{cmd_opcode, features_reg, sector_count_reg, drive_select_reg} = ~{op, ft, sc, drv};
		{lba_high_prev, lba_mid_prev, lba_low_prev, cylinder_reg, sector_number_reg} = ~lba;
		head_reg = ~lba[27:24];
		st = 2'bxx;
		for (n = 0; n < 8; n++) begin
			@(posedge clk);
			#1;
			if (cmd_done === 1'b1) begin
				st = {cmd_idnf, cmd_abort};
				break;
			end
		end
	endtask : issue
endmodule : amafc_host

// ---- tb/amafc_cmd_tb.sv ----
// Self-checking bench for the command interpreter: commands go through the host model,
// status, returned registers, maximum and feature outputs are compared.
`timescale 1ns/100ps
module amafc_cmd_tb;
	// Native maximum above the 28-bit range so the clamp is exercised
	localparam logic [47:0] NMAX = 48'h0012_3456_789A;
	localparam logic [47:0] A = 48'h0000_0123_4567;
	logic clk = 1'b0, reset = 1'b1, power_on = 1'b1, soft_reset = 1'b0, acc_valid = 1'b0;
	logic [47:0] acc_lba = 48'h0;
	logic cmd_valid, cmd_ready, cmd_done, cmd_abort, cmd_idnf, acc_done, acc_abort, frozen;
	logic [7:0] cmd_opcode, features_reg, sector_count_reg, sector_number_reg, drive_select_reg;
	logic [7:0] lba_low_prev, lba_mid_prev, lba_high_prev, sector_number_ret;
	logic [7:0] lba_low_prev_ret, lba_mid_prev_ret, lba_high_prev_ret, multiple_count, ecc_bytes;
	logic [15:0] cylinder_reg, cylinder_ret;
	logic [3:0] head_reg, head_ret;
	logic [47:0] max_lba;
	logic [31:0] id_words_60_61;
	logic [63:0] id_words_100_103;
	logic write_cache_en, look_ahead_en, apm_en, soft_revert_en, iordy_off, udma_sel;
	logic [1:0] apm_mode, st;
	logic [2:0] pio_mode, dma_mode;
	int failures = 0, check_count = 0, cycles = 0, i;

	always #12.5 clk = ~clk;

	amafc_host u_amafc_host (.clk(clk), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
		.cmd_abort(cmd_abort), .cmd_idnf(cmd_idnf), .cmd_valid(cmd_valid),
		.cmd_opcode(cmd_opcode), .features_reg(features_reg),
		.sector_count_reg(sector_count_reg), .sector_number_reg(sector_number_reg),
		.cylinder_reg(cylinder_reg), .head_reg(head_reg), .drive_select_reg(drive_select_reg),
		.lba_low_prev(lba_low_prev), .lba_mid_prev(lba_mid_prev), .lba_high_prev(lba_high_prev));

	amafc_cmd #(.NATIVE_MAX(NMAX)) u_amafc_cmd (.clk(clk), .reset(reset), .power_on(power_on),
		.soft_reset(soft_reset), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
		.features_reg(features_reg), .sector_count_reg(sector_count_reg),
		.sector_number_reg(sector_number_reg), .cylinder_reg(cylinder_reg), .head_reg(head_reg),
		.drive_select_reg(drive_select_reg), .lba_low_prev(lba_low_prev),
		.lba_mid_prev(lba_mid_prev), .lba_high_prev(lba_high_prev), .acc_valid(acc_valid),
		.acc_lba(acc_lba), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_abort(cmd_abort),
		.cmd_idnf(cmd_idnf), .sector_number_ret(sector_number_ret), .cylinder_ret(cylinder_ret),
		.head_ret(head_ret), .lba_low_prev_ret(lba_low_prev_ret),
		.lba_mid_prev_ret(lba_mid_prev_ret), .lba_high_prev_ret(lba_high_prev_ret),
		.acc_done(acc_done), .acc_abort(acc_abort), .frozen(frozen), .max_lba(max_lba),
		.id_words_60_61(id_words_60_61), .id_words_100_103(id_words_100_103),
		.write_cache_en(write_cache_en), .look_ahead_en(look_ahead_en), .apm_en(apm_en),
		.apm_mode(apm_mode), .soft_revert_en(soft_revert_en), .pio_mode(pio_mode),
		.iordy_off(iordy_off), .udma_sel(udma_sel), .dma_mode(dma_mode),
		.multiple_count(multiple_count), .ecc_bytes(ecc_bytes));

	task automatic chk(input string nm, input logic [63:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic test_done();
		if (failures == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : w

	task automatic rst(input logic po);
		reset = 1'b1;
		power_on = po;
		w(2);
		reset = 1'b0;
		power_on = 1'b0;
	endtask : rst

	// Two settle cycles: the maximum and identify words land the cycle after done
	task automatic cmd(input logic [7:0] op, ft, sc, drv, input logic [47:0] lba,
		input logic [1:0] ex);
		u_amafc_host.issue(op, ft, sc, drv, lba, st);
		chk($sformatf("status op %h ft %h sc %h", op, ft, sc), st, ex);
		w(2);
	endtask : cmd

	task automatic acc(input logic [47:0] a, input logic ex);
		acc_valid = 1'b1;
		acc_lba = a;
		w(1);
		chk("acc_done", acc_done, 1'b1);
		chk("acc_abort", acc_abort, ex);
		acc_valid = 1'b0;
		acc_lba = ~a;
		w(1);
		chk("acc_idle", acc_done, 1'b0);
	endtask : acc

	task automatic sf(input logic [7:0] ft, sc, input logic [1:0] ex);
		cmd(8'hEF, ft, sc, 8'h00, 48'h0, ex);
	endtask : sf

	// Cuts a hang short; the run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			test_done();
		end
	end

	initial begin
		rst(1'b1);
		chk("defaults", {write_cache_en, look_ahead_en, apm_en, apm_mode, soft_revert_en, pio_mode,
			iordy_off, udma_sel, dma_mode}, 14'b1_1_1_01_0_100_0_0_010);
		chk("ready", cmd_ready, 1'b1);
		chk("mult_ecc", {multiple_count, ecc_bytes}, 16'h1004);
		chk("max_po", max_lba, NMAX);
		cmd(8'hF8, 8'h00, 8'h00, 8'h40, 48'h0, 2'b00);
		chk("rd28", {head_ret, cylinder_ret, sector_number_ret}, 28'hFFF_FFFE);
		cmd(8'h37, 8'h00, 8'h01, 8'h40, A, 2'b01);
		cmd(8'h27, 8'h00, 8'h00, 8'h40, 48'h0, 2'b00);
		chk("rd48", {lba_high_prev_ret, lba_mid_prev_ret, lba_low_prev_ret, cylinder_ret,
			sector_number_ret}, NMAX);
		cmd(8'h37, 8'h00, 8'h01, 8'h40, A, 2'b00);
		chk("max_set", max_lba, A);
		chk("id60", id_words_60_61, 32'h0123_4568);
		chk("id100", id_words_100_103, 64'h0000_0000_0123_4568);
		acc(A + 48'h1, 1'b1);
		acc(A, 1'b0);
		cmd(8'h27, 8'h00, 8'h00, 8'h40, 48'h0, 2'b00);
		cmd(8'h37, 8'h00, 8'h01, 8'h40, 48'h0000_0200_0000, 2'b10);
		chk("max_idnf", max_lba, A);
		rst(1'b0);
		chk("max_keep", max_lba, A);
		cmd(8'h27, 8'h00, 8'h00, 8'h40, 48'h0, 2'b00);
		cmd(8'h37, 8'h00, 8'h00, 8'h40, 48'h0000_0080_0000, 2'b00);
		chk("max_vol", max_lba, 48'h0000_0080_0000);
		rst(1'b0);
		chk("max_revert", max_lba, A);
		cmd(8'hF8, 8'h00, 8'h00, 8'h40, 48'h0, 2'b00);
		cmd(8'hF9, 8'h04, 8'h00, 8'h40, 48'h0000_0040_0000, 2'b00);
		chk("not_frozen", frozen, 1'b0);
		chk("max28", max_lba, 48'h0000_0040_0000);
		cmd(8'h27, 8'h00, 8'h00, 8'h40, 48'h0, 2'b00);
		cmd(8'h37, 8'h00, 8'h00, 8'h40, A, 2'b01);
		rst(1'b0);
		cmd(8'hF9, 8'h04, 8'h00, 8'h40, 48'h0, 2'b01);
		chk("frz_nopw", frozen, 1'b0);
		cmd(8'hF9, 8'h01, 8'h00, 8'h40, 48'h0, 2'b00);
		cmd(8'hF9, 8'h04, 8'h00, 8'h40, 48'h0, 2'b00);
		chk("frozen", frozen, 1'b1);
		for (i = 1; i < 4; i++) begin
			cmd(8'hF9, 8'(i), 8'h00, 8'h40, 48'h0, 2'b01);
		end
		cmd(8'hF8, 8'h00, 8'h00, 8'h40, 48'h0, 2'b00);
		cmd(8'hF9, 8'h00, 8'h00, 8'h40, 48'h0000_0000_0010, 2'b01);
		chk("max_frz", max_lba, A);
		sf(8'h82, 8'h00, 2'b00);
		chk("wc_off", write_cache_en, 1'b0);
		sf(8'h02, 8'h00, 2'b00);
		chk("wc_on", write_cache_en, 1'b1);
		sf(8'h55, 8'h00, 2'b00);
		chk("la_off", look_ahead_en, 1'b0);
		sf(8'hAA, 8'h00, 2'b00);
		chk("la_on", look_ahead_en, 1'b1);
		sf(8'h85, 8'h00, 2'b00);
		chk("apm_off", {apm_en, apm_mode}, 3'b001);
		sf(8'h05, 8'hFE, 2'b00);
		chk("apm_m0", {apm_en, apm_mode}, 3'b100);
		sf(8'h05, 8'h80, 2'b00);
		chk("apm_m1", apm_mode, 2'h1);
		sf(8'h05, 8'h7F, 2'b00);
		chk("apm_m2", apm_mode, 2'h2);
		sf(8'h05, 8'h00, 2'b01);
		sf(8'h05, 8'hFF, 2'b01);
		chk("apm_keep", apm_mode, 2'h2);
		sf(8'h03, 8'h0B, 2'b00);
		chk("pio3", pio_mode, 3'h3);
		sf(8'h03, 8'h22, 2'b00);
		chk("mwdma2", {udma_sel, dma_mode}, 4'h2);
		sf(8'h03, 8'h45, 2'b00);
		chk("udma5", {udma_sel, dma_mode}, 4'hD);
		sf(8'h03, 8'h01, 2'b00);
		chk("pio_def_noiordy", {pio_mode, iordy_off}, 4'h9);
		sf(8'h03, 8'h00, 2'b00);
		chk("pio_def", {pio_mode, iordy_off}, 4'h8);
		sf(8'h03, 8'h80, 2'b01);
		sf(8'h03, 8'h02, 2'b01);
		chk("pio_keep", {pio_mode, iordy_off, udma_sel}, 5'h11);
		sf(8'h00, 8'h00, 2'b01);
		sf(8'h99, 8'h00, 2'b01);
		chk("task_file", {head_ret, cylinder_ret, sector_number_ret}, 28'hFFF_FFFE);
		cmd(8'hF8, 8'h00, 8'h00, 8'h00, 48'h0, 2'b00);
		chk("rd_chs", {head_ret, cylinder_ret, sector_number_ret}, 28'hF_3FFF_3F);
		sf(8'hCC, 8'h00, 2'b00);
		chk("revert_on", soft_revert_en, 1'b1);
		sf(8'h82, 8'h00, 2'b00);
		soft_reset = 1'b1;
		w(1);
		soft_reset = 1'b0;
		w(2);
		chk("soft_revert", write_cache_en, 1'b1);
		sf(8'h66, 8'h00, 2'b00);
		sf(8'h82, 8'h00, 2'b00);
		soft_reset = 1'b1;
		w(1);
		soft_reset = 1'b0;
		w(2);
		chk("soft_keep", {soft_revert_en, write_cache_en}, 2'b00);
		test_done();
	end
endmodule : amafc_cmd_tb
